// File: design/swt_consts.vh
// Constants of the supervisor watchdog timer.
// Assumes inclusion by bare name from the design files.
`ifndef SWT_CONSTS_VH
`define SWT_CONSTS_VH

// Internal oscillator rate in Hz
`define SWT_OSC_HZ 10240
// Clock rate of the block in Hz
`define SWT_CLK_HZ 125000000
// External clock counts
`define SWT_EXT_NORMAL 1024
`define SWT_EXT_LONG 4096
`define SWT_EXT_RESET 2048
// Internal times in ms
`define SWT_INT_SHORT_MS 100
`define SWT_INT_LONG_MS 1600
`define SWT_INT_RESET_MS 200
// Timebase tick counter width
`define SWT_CNT_W 16
// States
`define SWT_ST_OFF 2'h0
`define SWT_ST_RUN 2'h1
`define SWT_ST_RST 2'h2

`endif

// File: design/swt_tick_gen.v
// Timebase tick generator: internal oscillator divider or external edge.
// Assumes timebase_input is synchronous to clk.
`timescale 1ns/1ps
`include "swt_consts.vh"
module swt_tick_gen #(
   parameter DIV = `SWT_CLK_HZ / `SWT_OSC_HZ
) (
   input wire clk,
   input wire rst_b,
   input wire use_internal,
   input wire timebase_input,
   output reg tick_reg
);
   reg [15:0] div_reg;
   reg [15:0] div_next;
   reg tb_meta_reg;
   reg tb_sync_reg;
   reg tb_prev_reg;
   always @* begin
      div_next = div_reg + 16'h0001;
      if (div_reg == DIV[15:0] - 16'h0001) begin
         div_next = 16'h0000;
      end
   end
   always @(posedge clk) begin
      if (!rst_b) begin
         div_reg <= 16'h0000;
         tb_meta_reg <= 1'b0;
         tb_sync_reg <= 1'b0;
         tb_prev_reg <= 1'b0;
         tick_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         tb_meta_reg <= timebase_input;
         tb_sync_reg <= tb_meta_reg;
         tb_prev_reg <= tb_sync_reg;
         if (use_internal) begin
            tick_reg <= (div_reg == 16'h0000);
         end else begin
            tick_reg <= tb_sync_reg & ~tb_prev_reg;
         end
      end
   end
endmodule

// File: design/swt_watchdog.v
// Watchdog timer: kick edge detection, timeouts, reset and expiry outputs.
// Assumes all inputs synchronous to clk; power_low from analog comparators.
`timescale 1ns/1ps
`include "swt_consts.vh"
module swt_watchdog #(
   parameter EXT_NORMAL = `SWT_EXT_NORMAL,
   parameter EXT_LONG = `SWT_EXT_LONG,
   parameter EXT_RESET = `SWT_EXT_RESET,
   parameter INT_SHORT = `SWT_INT_SHORT_MS * `SWT_OSC_HZ / 1000,
   parameter INT_LONG = `SWT_INT_LONG_MS * `SWT_OSC_HZ / 1000,
   parameter INT_RESET = `SWT_INT_RESET_MS * `SWT_OSC_HZ / 1000,
   parameter OSC_DIV = `SWT_CLK_HZ / `SWT_OSC_HZ
) (
   input wire clk,
   input wire rst_b,
   input wire watchdog_kick_in,
   input wire kick_connected,
   input wire timebase_select,
   input wire timebase_input,
   input wire power_low,
   output reg reset_out_b_reg,
   output reg watchdog_expired_out
);
   localparam W = `SWT_CNT_W;
   // Two flops settle the pin, the third keeps the last level seen
   localparam SYNC = 3;
   localparam [1:0] ST_OFF = `SWT_ST_OFF;
   localparam [1:0] ST_RUN = `SWT_ST_RUN;
   localparam [1:0] ST_RST = `SWT_ST_RST;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [W-1:0] cnt_reg;
   reg [W-1:0] cnt_next;
   reg long_reg;
   reg long_next;
   reg wdo_next;
   reg rstb_next;
   reg [SYNC-1:0] kick_pipe_reg;
   reg [W-1:0] limit_to;
   wire tick;
   wire kick_edge;
   wire active;
   wire [W-1:0] limit_rst;

   function [W-1:0] pick;
      input sel;
      input [W-1:0] a;
      input [W-1:0] b;
      begin
         pick = sel ? a : b;
      end
   endfunction

   // Last count of a period, shared by timeout and reset pulse
   function reached;
      input [W-1:0] count;
      input [W-1:0] limit;
      begin
         reached = (count >= limit - {{(W-1){1'b0}}, 1'b1});
      end
   endfunction

   function [W-1:0] bump;
      input [W-1:0] count;
      begin
         bump = count + {{(W-1){1'b0}}, 1'b1};
      end
   endfunction

   swt_tick_gen #(
      .DIV(OSC_DIV)
   ) u_tick (
      .clk(clk),
      .rst_b(rst_b),
      .use_internal(timebase_select),
      .timebase_input(timebase_input),
      .tick_reg(tick)
   );

   // Kick pin passes a short chain; only stage one reads the raw pin
   genvar gi;
   generate
      for (gi = 0; gi < SYNC; gi = gi + 1) begin : g_kick
         if (gi == 0) begin : g_first
            always @(posedge clk) begin
               if (!rst_b) begin
                  kick_pipe_reg[gi] <= 1'b0;
               end else begin
                  kick_pipe_reg[gi] <= watchdog_kick_in;
               end
            end
         end else begin : g_next
            always @(posedge clk) begin
               if (!rst_b) begin
                  kick_pipe_reg[gi] <= 1'b0;
               end else begin
                  kick_pipe_reg[gi] <= kick_pipe_reg[gi-1];
               end
            end
         end
      end
   endgenerate

   // While long_reg is clear, pin level of timebase_input picks the short or long internal period
   always @* begin
      case ({timebase_select, long_reg | timebase_input})
         2'h3: begin
            limit_to = INT_LONG[W-1:0];
         end
         2'h2: begin
            limit_to = INT_SHORT[W-1:0];
         end
         default: begin
            limit_to = pick(long_reg, EXT_LONG[W-1:0],
               EXT_NORMAL[W-1:0]);
         end
      endcase
   end

   assign limit_rst = pick(timebase_select, INT_RESET[W-1:0],
      EXT_RESET[W-1:0]);
   // Both polarities count, so a plain difference of the last two
   assign kick_edge = kick_pipe_reg[SYNC-1] ^ kick_pipe_reg[SYNC-2];
   assign active = kick_connected & ~power_low;

   always @* begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      long_next = long_reg;
      wdo_next = watchdog_expired_out;
      rstb_next = 1'b1;
      case (state_reg)
         ST_OFF: begin
            cnt_next = {W{1'b0}};
            long_next = 1'b1;
            if (active) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (kick_edge) begin
               cnt_next = {W{1'b0}};
               long_next = 1'b0;
               wdo_next = 1'b1;
            end else if (tick) begin
               if (reached(cnt_reg, limit_to)) begin
                  // Expired: repeats while kick stays still
                  cnt_next = {W{1'b0}};
                  wdo_next = 1'b0;
                  rstb_next = 1'b0;
                  state_next = ST_RST;
               end else begin
                  cnt_next = bump(cnt_reg);
               end
            end
         end
         ST_RST: begin
            rstb_next = 1'b0;
            // Kick during the pulse clears the flag, not the long period
            long_next = 1'b1;
            if (kick_edge) begin
               wdo_next = 1'b1;
            end
            if (tick) begin
               if (reached(cnt_reg, limit_rst)) begin
                  cnt_next = {W{1'b0}};
                  rstb_next = 1'b1;
                  state_next = ST_RUN;
               end else begin
                  cnt_next = bump(cnt_reg);
               end
            end
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
      // Idle wins over a pulse in flight, so reset never sticks low
      if (!active) begin
         state_next = ST_OFF;
         rstb_next = 1'b1;
      end
      if (power_low) begin
         wdo_next = 1'b1;
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         state_reg <= ST_OFF;
         cnt_reg <= {W{1'b0}};
         long_reg <= 1'b1;
         reset_out_b_reg <= 1'b1;
         watchdog_expired_out <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         long_reg <= long_next;
         reset_out_b_reg <= rstb_next;
         watchdog_expired_out <= wdo_next;
      end
   end
endmodule

// File: verif/swt_host.sv
// Host model toggling the kick input.
// Assumes go and gap change at the falling edge.
`timescale 1ns/1ps
module swt_host (
   input wire clk,
   input wire go,
   input wire [7:0] gap,
   output reg kick
);
   reg [7:0] cnt_reg = 8'h00;
   initial kick = 1'b0;
   // Either polarity counts, so a toggle serves
   always @(negedge clk) begin
      cnt_reg <= cnt_reg + 8'h01;
      if (go && cnt_reg >= gap) begin
         kick <= ~kick;
         cnt_reg <= 8'h00;
      end
   end
endmodule

// File: verif/swt_watchdog_chk.sv
// Checker of the watchdog outputs.
// Assumes one clock and binding to swt_watchdog.
`timescale 1ns/1ps
module swt_watchdog_chk (
   input wire clk,
   input wire rst_b,
   input wire watchdog_kick_in,
   input wire kick_connected,
   input wire power_low,
   input wire reset_out_b_reg,
   input wire watchdog_expired_out
);
   reg [5:0] kh_reg;
   always @(posedge clk) kh_reg <= {kh_reg[4:0], watchdog_kick_in};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_plw; power_low [*2] |-> watchdog_expired_out; endproperty
   a_plw: assert property (p_plw) else $error("flag low");
   property p_plr; power_low [*2] |-> reset_out_b_reg; endproperty
   a_plr: assert property (p_plr) else $error("reset low");
   property p_flt; !kick_connected [*2] |-> reset_out_b_reg; endproperty
   a_flt: assert property (p_flt) else $error("reset float");
   property p_fr; $fell(reset_out_b_reg) |-> !watchdog_expired_out;
   endproperty
   a_fr: assert property (p_fr) else $error("flag high");
   property p_fw; $fell(watchdog_expired_out) |-> $fell(reset_out_b_reg);
   endproperty
   a_fw: assert property (p_fw) else $error("flag alone");
   property p_rl; $fell(reset_out_b_reg) |=> !reset_out_b_reg [*8];
   endproperty
   a_rl: assert property (p_rl) else $error("pulse short");
   property p_rh; $rose(reset_out_b_reg) |=> reset_out_b_reg [*8];
   endproperty
   a_rh: assert property (p_rh) else $error("fast expiry");
   // Kick seen within six cycles explains a rise
   property p_wr; $rose(watchdog_expired_out) |-> power_low
      || $past(power_low) || (kh_reg != 6'h00 && kh_reg != 6'h3f);
   endproperty
   a_wr: assert property (p_wr) else $error("flag rose");
endmodule
bind swt_watchdog swt_watchdog_chk u_chk (.clk(clk), .rst_b(rst_b),
   .watchdog_kick_in(watchdog_kick_in), .kick_connected(kick_connected),
   .power_low(power_low), .reset_out_b_reg(reset_out_b_reg),
   .watchdog_expired_out(watchdog_expired_out));

// File: verif/tb_top.sv
// Bench of the watchdog on small external and internal timebases.
// Assumes host model and bound checker compiled first.
`timescale 1ns/1ps
module tb_top;
   reg clk, rst_b, kick_connected, timebase_select;
   reg timebase_input = 1'b0;
   reg power_low, go;
   reg ph = 1'b0, tb_d = 1'b0, kd = 1'b0, rd = 1'b1;
   reg [7:0] gap;
   reg [15:0] e;
   int cnt = 0, i, error_cnt, total_checks;
   logic [15:0] q[$];
   wire kick, reset_out_b_reg, watchdog_expired_out;
   swt_host host (.clk(clk), .go(go), .gap(gap), .kick(kick));
   swt_watchdog #(.EXT_NORMAL(8), .EXT_LONG(16), .EXT_RESET(4),
      .INT_SHORT(8), .INT_LONG(16), .INT_RESET(12), .OSC_DIV(1)) dut (
      .clk(clk), .rst_b(rst_b), .watchdog_kick_in(kick),
      .kick_connected(kick_connected), .timebase_select(timebase_select),
      .timebase_input(timebase_input), .power_low(power_low),
      .reset_out_b_reg(reset_out_b_reg),
      .watchdog_expired_out(watchdog_expired_out));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("errors %0d checks %0d", error_cnt, total_checks);
      if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Notes a timeout and a pulse length in timebase edges
   task note(input logic [15:0] a, input logic [15:0] b);
      q.push_back(a);
      q.push_back(b);
      for (i = 0; i < 3000 && q.size() > 0; i++) @(negedge clk);
      if (q.size() > 0) chk(16'h0, 16'h1);
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(negedge clk) begin
      ph <= ~ph;
      if (ph) timebase_input <= ~timebase_input;
   end
   // Sync delay blurs counts by one edge, hence the tolerance
   always @(negedge clk) begin
      tb_d <= timebase_input;
      kd <= kick;
      rd <= reset_out_b_reg;
      if (rd !== reset_out_b_reg) begin
         e = q.size() ? q.pop_front() : 16'hffff;
         chk((cnt + 1 >= e && cnt + 1 - e <= 2) ? e : cnt, e);
         cnt <= 0;
      end else if (power_low || !kick_connected || kd != kick) cnt <= 0;
      else if (timebase_select || (timebase_input && !tb_d)) cnt <= cnt + 1;
   end
   initial begin
      #400000;
      error_cnt++;
      finish_test;
   end
   initial begin
      {rst_b, kick_connected, timebase_select} = 3'h0;
      {power_low, go} = 2'h0;
      {gap, error_cnt, total_checks} = 0;
      void'($urandom(32'ha052));
      repeat (5) @(negedge clk);
      rst_b <= 1'b1;
      kick_connected <= 1'b1;
      note(16'h10, 16'h4);
      @(negedge clk) go <= 1'b1;
      @(negedge clk) go <= 1'b0;
      note(16'h8, 16'h4);
      note(16'h10, 16'h4);
      power_low <= 1'b1;
      repeat (3) @(negedge clk);
      chk({15'h0, watchdog_expired_out}, 16'h1);
      repeat (200) @(negedge clk);
      power_low <= 1'b0;
      note(16'h10, 16'h4);
      kick_connected <= 1'b0;
      repeat (200) @(negedge clk);
      gap <= 8'($urandom_range(20, 4));
      go <= 1'b1;
      kick_connected <= 1'b1;
      repeat (600) @(negedge clk);
      go <= 1'b0;
      chk({15'h0, watchdog_expired_out}, 16'h1);
      // Internal timebase, one tick per clock: counts are in clocks
      kick_connected <= 1'b0;
      timebase_select <= 1'b1;
      repeat (4) @(negedge clk);
      kick_connected <= 1'b1;
      note(16'h10, 16'hc);
      finish_test;
   end
endmodule
